// File: rtl/osa_pkg.sv
// package for the oversampling averager: widths, ratio codes, timing counts
// assumes a 125 MHz system clock; OSA_SAMPLE_CYC is in cycles of that clock, the sample period in ns
// Function
// - ratio select 000 no averaging, 001..110 give 2..64, 111 invalid.
// - burst period scales with ratio, 200 kSPS down to 3.125 kSPS.
// - first burst sample taken at rising edge of both start inputs.
// - remaining burst samples triggered internally, no further host edges.
// - average burst per channel, decimate to one 18-bit word each.
// - front-end gain follows the range select pin level.
// - reference select high uses internal 2.5 V and drives reference pin.
// - range pin high means 10 V range, low means 5 V range.
// - reference select low powers down band-gap, pin becomes input.
// - results are 18-bit two's complement on every channel and range.
package osa_pkg;
   localparam int OSA_CHANNELS = 8;
   localparam int OSA_SAMPLE_W = 18;
   localparam int OSA_ACC_W = 24;
   localparam int OSA_CLK_MHZ = 125;
   // sample period at 200 kSPS in ns
   localparam int OSA_SAMPLE_PERIOD_NS = 5000;
   localparam int OSA_SAMPLE_CYC = (OSA_SAMPLE_PERIOD_NS * OSA_CLK_MHZ) / 1000;
   localparam logic [2:0] OSA_OS_NONE = 3'h0;
   localparam logic [2:0] OSA_OS_INVALID = 3'h7;
   localparam logic [6:0] OSA_MAX_RATIO = 7'h40;

   typedef logic signed [OSA_SAMPLE_W-1:0] osa_sample_t;

   typedef struct packed {
      logic range_10v;
      logic gain_high;
   } osa_gain_t;

   typedef struct packed {
      logic bandgap_enable;
      logic ref_out;
      logic ref_oe_n;
   } osa_ref_t;

   typedef enum logic [1:0] {
      OSA_IDLE,
      OSA_CONVERT,
      OSA_WAIT,
      OSA_DONE
   } osa_state_t;
endpackage

// File: rtl/osa_acc_mem.sv
// per-channel accumulator memory for the oversampling averager
// assumes one write per cycle; read data come out of a register
`timescale 1ns/1ps
module osa_acc_mem #(
   parameter int DEPTH = 8,
   parameter int WIDTH = 24
) (
   // clock
   input wire logic i_clock,
   // write port
   input wire logic i_we,
   input wire logic [$clog2(DEPTH)-1:0] i_waddr,
   input wire logic [WIDTH-1:0] i_wdata,
   // read port
   input wire logic [$clog2(DEPTH)-1:0] i_raddr,
   output logic [WIDTH-1:0] o_rdata
);
   logic [WIDTH-1:0] mem_r [DEPTH];

   always_ff @(posedge i_clock) begin
      if (i_we) begin
         mem_r[i_waddr] <= i_wdata;
      end
   end

   always_ff @(posedge i_clock) begin
      o_rdata <= mem_r[i_raddr];
   end
endmodule

// File: rtl/osa_averager.sv
// oversampling averaging filter for an eight-channel simultaneous converter
// assumes the converter core returns one sample per channel, sequentially
`timescale 1ns/1ps
module osa_averager
   import osa_pkg::*;
#(
   parameter int CHANNELS = osa_pkg::OSA_CHANNELS,
   parameter int SAMPLE_CYC = osa_pkg::OSA_SAMPLE_CYC
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_sys_rst,
   // host control pins
   input wire logic i_convert_start_a,
   input wire logic i_convert_start_b,
   input wire logic [2:0] i_oversample_ratio_select,
   input wire logic i_range_select,
   input wire logic i_reference_source_select,
   // converter core sample stream
   input wire logic i_sample_valid,
   input wire osa_pkg::osa_sample_t i_sample,
   // converter core control
   output logic o_sample_trigger,
   output osa_pkg::osa_gain_t o_front_end_gain_stage,
   output osa_pkg::osa_ref_t o_reference_io_pin,
   // results
   output logic o_result_valid,
   output logic [2:0] o_result_channel,
   output osa_pkg::osa_sample_t o_result,
   output logic o_busy,
   output logic o_invalid_ratio
);
   import osa_pkg::*;

   localparam int CH_W = $clog2(CHANNELS);

   function automatic logic [6:0] ratio_of(input logic [2:0] sel);
      if (sel == OSA_OS_INVALID) begin
         return 7'h01;
      end
      return 7'(7'h01 << sel);
   endfunction

   // true while the round being collected is the last one of the burst
   function automatic logic is_last_round(input logic [6:0] taken, input logic [6:0] ratio);
      return (7'(taken + 7'h01) == ratio);
   endfunction

   osa_state_t state_r;
   logic start_a_d_r;
   logic start_b_d_r;
   logic [2:0] shift_r;
   logic [6:0] ratio_r;
   logic [6:0] taken_r;
   logic [15:0] period_r;
   logic [CH_W-1:0] chan_r;
   logic burst_go;
   logic take;
   logic round_end;
   logic last_round;
   logic trigger_nxt;
   logic [OSA_ACC_W-1:0] acc_rd;
   logic [OSA_ACC_W-1:0] acc_wdata;
   logic start_edge;

   // both start inputs high, at least one freshly risen
   assign start_edge = i_convert_start_a && i_convert_start_b &&
                       (!start_a_d_r || !start_b_d_r);

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         start_a_d_r <= 1'b0;
         start_b_d_r <= 1'b0;
      end else begin
         start_a_d_r <= i_convert_start_a;
         start_b_d_r <= i_convert_start_b;
      end
   end

   // static configuration pins
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_front_end_gain_stage <= '0;
         o_reference_io_pin <= '{bandgap_enable: 1'b0, ref_out: 1'b0, ref_oe_n: 1'b1};
         o_invalid_ratio <= 1'b0;
      end else begin
         o_front_end_gain_stage.range_10v <= i_range_select;
         o_front_end_gain_stage.gain_high <= i_range_select;
         o_reference_io_pin.bandgap_enable <= i_reference_source_select;
         o_reference_io_pin.ref_out <= i_reference_source_select;
         o_reference_io_pin.ref_oe_n <= !i_reference_source_select;
         o_invalid_ratio <= (i_oversample_ratio_select == OSA_OS_INVALID);
      end
   end

   // a start edge counts only when idle and the code is legal
   assign burst_go = start_edge && (state_r == OSA_IDLE) &&
                     (i_oversample_ratio_select != OSA_OS_INVALID);
   assign take = (state_r == OSA_CONVERT) && i_sample_valid;
   assign round_end = take && (chan_r == CH_W'(CHANNELS - 1));
   assign last_round = is_last_round(taken_r, ratio_r);
   // internal trigger paced at the base sample rate
   assign trigger_nxt = burst_go || (state_r == OSA_WAIT && period_r == 16'h0000);

   // ratio latched at the start edge; 000 gives a one-sample burst
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         ratio_r <= 7'h01;
         shift_r <= 3'h0;
      end else if (burst_go) begin
         ratio_r <= ratio_of(i_oversample_ratio_select);
         shift_r <= i_oversample_ratio_select;
      end
   end

   // channel within a round and rounds taken within a burst
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         chan_r <= '0;
         taken_r <= 7'h00;
      end else if (burst_go) begin
         chan_r <= '0;
         taken_r <= 7'h00;
      end else if (take) begin
         chan_r <= round_end ? '0 : chan_r + CH_W'(1);
         if (round_end) begin
            taken_r <= taken_r + 7'h01;
         end
      end
   end

   // base sample period, reloaded at every trigger
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         period_r <= 16'h0000;
      end else if (trigger_nxt) begin
         period_r <= 16'(SAMPLE_CYC - 1);
      end else if (period_r != 16'h0000) begin
         period_r <= period_r - 16'h0001;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_sample_trigger <= 1'b0;
      end else begin
         o_sample_trigger <= trigger_nxt;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_busy <= 1'b0;
      end else if (burst_go) begin
         o_busy <= 1'b1;
      end else if (state_r == OSA_DONE) begin
         o_busy <= 1'b0;
      end
   end

   // burst sequencer
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         state_r <= OSA_IDLE;
      end else begin
         case (state_r)
            OSA_IDLE: begin
               if (burst_go) begin
                  state_r <= OSA_CONVERT;
               end
            end
            OSA_CONVERT: begin
               if (round_end) begin
                  state_r <= last_round ? OSA_DONE : OSA_WAIT;
               end
            end
            OSA_WAIT: begin
               // wait out the base period before the next internal trigger
               if (period_r == 16'h0000) begin
                  state_r <= OSA_CONVERT;
               end
            end
            OSA_DONE: begin
               state_r <= OSA_IDLE;
            end
            default: begin
               state_r <= OSA_IDLE;
            end
         endcase
      end
   end

   // accumulate: each channel's first sample of the burst replaces its stored sum
   assign acc_wdata = (taken_r == 7'h00) ? OSA_ACC_W'(i_sample) :
                      acc_rd + OSA_ACC_W'(i_sample);

   osa_acc_mem #(
      .DEPTH(CHANNELS),
      .WIDTH(OSA_ACC_W)
   ) u_acc (
      .i_clock(i_clock),
      .i_we(take),
      .i_waddr(chan_r),
      .i_wdata(acc_wdata),
      .i_raddr(take ? chan_r + CH_W'(1) : chan_r),
      .o_rdata(acc_rd)
   );

   // result stage: the final sample's sum is shifted and emitted
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_result_valid <= 1'b0;
         o_result_channel <= 3'h0;
         o_result <= '0;
      end else begin
         o_result_valid <= 1'b0;
         if (take && last_round) begin
            o_result_valid <= 1'b1;
            o_result_channel <= 3'(chan_r);
            o_result <= OSA_SAMPLE_W'($signed(acc_wdata) >>> shift_r);
         end
      end
   end
endmodule

// File: dv/osa_core_model.sv
// converter core model: answers each sample trigger with eight channel samples
// assumes the averager's trigger and busy outputs; samples ride on one clock
`timescale 1ns/1ps
module osa_core_model
   import osa_pkg::*;
(
   // averager side
   input wire logic i_clock,
   input wire logic i_sample_trigger,
   input wire logic i_busy,
   output logic o_sample_valid = 1'b0,
   output osa_pkg::osa_sample_t o_sample = '0
);
   logic [3:0] step_r = 4'h0;
   logic [6:0] round_r = 7'h0;
   always_ff @(posedge i_clock) begin
      if (i_sample_trigger)
         step_r <= 4'h1;
      else if (step_r != 4'h0)
         step_r <= (step_r == 4'hA) ? 4'h0 : step_r + 4'h1;
   end
   always_ff @(posedge i_clock) begin
      if (!i_busy)
         round_r <= 7'h0;
      else if (step_r == 4'hA)
         round_r <= round_r + 7'h1;
   end
   // channel c of round r carries c*8-30+r; an idle bus shows the inverse
   always_ff @(posedge i_clock) begin
      o_sample_valid <= step_r >= 4'h2 && step_r <= 4'h9;
      o_sample <= (step_r >= 4'h2 && step_r <= 4'h9) ?
         18'(step_r) * 18'h8 - 18'h2E + 18'(round_r) : ~o_sample;
   end
endmodule

// File: dv/osa_averager_asserts.sv
// timing checker for the oversampling averager's control and result ports
// assumes it is bound into osa_averager
`timescale 1ns/1ps
module osa_averager_asserts
   import osa_pkg::*;
#(
   parameter int SAMPLE_CYC = 625
) (
   // watched ports
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_convert_start_a,
   input wire logic i_convert_start_b,
   input wire logic [2:0] i_oversample_ratio_select,
   input wire logic i_range_select,
   input wire logic i_reference_source_select,
   input wire logic i_sample_valid,
   input wire logic o_sample_trigger,
   input wire osa_pkg::osa_gain_t o_front_end_gain_stage,
   input wire osa_pkg::osa_ref_t o_reference_io_pin,
   input wire logic o_result_valid,
   input wire logic [2:0] o_result_channel,
   input wire logic o_busy,
   input wire logic o_invalid_ratio
);
   default clocking @(posedge i_clock);
   endclocking
   default disable iff (i_sys_rst);
   logic both_r;
   logic go_w;
   logic [15:0] gap_r;
   always_ff @(posedge i_clock) begin
      both_r <= i_convert_start_a && i_convert_start_b;
   end
   // cycles since the last trigger, saturating
   always_ff @(posedge i_clock) begin
      if (o_sample_trigger)
         gap_r <= 16'h0001;
      else if (gap_r != 16'hFFFF)
         gap_r <= gap_r + 16'h0001;
   end
   assign go_w = i_convert_start_a && i_convert_start_b && !both_r && !o_busy &&
      i_oversample_ratio_select != 3'h7;
   sequence trig_gap_s;
      !o_sample_trigger [*8];
   endsequence
   start_trig_a: assert property (go_w |=> o_sample_trigger) else $error("no trigger");
   idle_quiet_a: assert property (!o_busy && !go_w |=> !o_sample_trigger) else $error("stray");
   trig_gap_a: assert property (o_sample_trigger |=> trig_gap_s) else $error("gap");
   trig_busy_a: assert property (o_sample_trigger |-> o_busy) else $error("idle trig");
   result_follow_a: assert property (o_result_valid |-> $past(i_sample_valid) && o_busy)
      else $error("result timing");
   chan_order_a: assert property (o_result_valid && $past(o_result_valid) |->
      o_result_channel == $past(o_result_channel) + 3'h1) else $error("channel order");
   gain_follow_a: assert property (!$past(i_sys_rst) |->
      o_front_end_gain_stage.range_10v == $past(i_range_select) &&
      o_front_end_gain_stage.gain_high == $past(i_range_select)) else $error("range");
   trig_space_a: assert property (o_sample_trigger && $past(o_busy) |->
      gap_r == 16'(SAMPLE_CYC)) else $error("trigger pacing");
   ratio_flag_a: assert property (!$past(i_sys_rst) |->
      o_invalid_ratio == ($past(i_oversample_ratio_select) == 3'h7)) else $error("ratio flag");
   ref_follow_a: assert property (!$past(i_sys_rst) |->
      o_reference_io_pin.bandgap_enable == $past(i_reference_source_select) &&
      o_reference_io_pin.ref_out == $past(i_reference_source_select) &&
      o_reference_io_pin.ref_oe_n == !$past(i_reference_source_select)) else $error("ref");
endmodule
bind osa_averager osa_averager_asserts #(.SAMPLE_CYC(SAMPLE_CYC)) u_osa_chk (
   .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_convert_start_a(i_convert_start_a),
   .i_convert_start_b(i_convert_start_b), .i_oversample_ratio_select(i_oversample_ratio_select),
   .i_range_select(i_range_select), .i_reference_source_select(i_reference_source_select),
   .i_sample_valid(i_sample_valid), .o_sample_trigger(o_sample_trigger),
   .o_front_end_gain_stage(o_front_end_gain_stage), .o_reference_io_pin(o_reference_io_pin),
   .o_result_valid(o_result_valid), .o_result_channel(o_result_channel), .o_busy(o_busy),
   .o_invalid_ratio(o_invalid_ratio));

// File: dv/osa_averager_bench.sv
// self-checking bench: bursts at every ratio code, refused starts, static pins
// assumes the core model answers triggers; SAMPLE_CYC shortened to 20
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; $display("Error %0t: mismatch", $time); end end
module osa_averager_bench;
   import osa_pkg::*;
   logic i_clock = 1'b0;
   logic i_sys_rst = 1'b1;
   logic st_a = 1'b0, st_b = 1'b0, rng = 1'b0, rsel = 1'b0;
   logic [2:0] os_sel = 3'h0, rch;
   logic svalid, trig, rvalid, busy, inval;
   osa_sample_t sample, res;
   osa_sample_t exp_a [8];
   osa_gain_t gain;
   osa_ref_t refp;
   int mismatches = 0, check_count = 0, trig_n = 0, res_n = 0, cyc = 0;
   localparam int BENCH_CYC = 20;
   osa_averager #(.SAMPLE_CYC(BENCH_CYC)) u_dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
      .i_convert_start_a(st_a), .i_convert_start_b(st_b), .i_oversample_ratio_select(os_sel),
      .i_range_select(rng), .i_reference_source_select(rsel), .i_sample_valid(svalid),
      .i_sample(sample), .o_sample_trigger(trig), .o_front_end_gain_stage(gain),
      .o_reference_io_pin(refp), .o_result_valid(rvalid), .o_result_channel(rch),
      .o_result(res), .o_busy(busy), .o_invalid_ratio(inval));
   osa_core_model u_core (.i_clock(i_clock), .i_sample_trigger(trig), .i_busy(busy),
      .o_sample_valid(svalid), .o_sample(sample));
   always #4 i_clock = ~i_clock;
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge i_clock) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         test_done();
      end
      if (trig === 1'b1)
         trig_n++;
      if (rvalid === 1'b1) begin
         `CHK(rch, 3'(res_n))
         `CHK(res, exp_a[res_n % 8])
         res_n++;
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask
   task automatic burst(input logic [2:0] code);
      int s;
      for (int c = 0; c < 8; c++) begin
         s = 0;
         for (int r = 0; r < (1 << code); r++)
            s += c * 8 - 30 + r;
         exp_a[c] = osa_sample_t'(s >>> code);
      end
      trig_n = 0;
      res_n = 0;
      os_sel = code;
      {st_a, st_b} = 2'h3;
      tick(2);
      {st_a, st_b} = 2'h0;
      tick(1);
      {st_a, st_b} = 2'h3;
      tick(1);
      {st_a, st_b} = 2'h0;
      for (int i = 0; i < 5000 && busy !== 1'b0; i++)
         tick(1);
      tick(BENCH_CYC);
      `CHK(trig_n, (code == 3'h7) ? 0 : (1 << code))
      `CHK(res_n, (code == 3'h7) ? 0 : 8)
      $display("test burst code %0d done", code);
   endtask
   initial begin
      tick(6);
      `CHK(refp.ref_oe_n, 1'b1)
      `CHK(busy, 1'b0)
      i_sys_rst = 1'b0;
      for (int c = 0; c < 8; c++)
         burst(3'(c));
      `CHK(inval, 1'b1)
      os_sel = 3'h6;
      tick(2);
      `CHK(inval, 1'b0)
      for (int v = 1; v >= 0; v--) begin
         rng = 1'(v);
         rsel = 1'(v);
         tick(2);
         `CHK(gain.range_10v, 1'(v))
         `CHK(gain.gain_high, 1'(v))
         `CHK(refp.ref_out, 1'(v))
         `CHK(refp.bandgap_enable, 1'(v))
         `CHK(refp.ref_oe_n, !1'(v))
      end
      $display("test static pins done");
      test_done();
   end
endmodule
